// ---- design/usb_irq_defs.svh ----
// Purpose: Offsets, bit positions, reset values and timing counts of the USB interrupt block.
// Assumes: Register offsets are word indexes; byte address is four times the index.
// Notes:   Definitions only.
//
// Summary of operation
// - Bus reset detection sets event bit 4; writing one clears it.
// - Three milliseconds without bus activity sets event bit 3; writing one clears it.
// - A received SETUP token sets event bit 2; writing one clears it.
// - A received start-of-frame packet sets event bit 1; writing one clears it.
// - Eight SETUP bytes copied to setup registers set event bit 0; write one clears.
// - Event flags clear only at power-on reset and update during processor reset.
// - Disabled endpoint flags are held but not forwarded; enabled ones raise the request.
// - Endpoint enables affect only interrupt generation, never endpoint transfers.
// - Each event enable bit masks the event flag at the same position.
// - Address match sets break flag bit 3; the break pin follows the flag.
// - Writing one clears the break flag; pulse mode needs no clearing.
// - Pulse mode holds break high 8 reference-clock cycles; else until cleared.
// - With break enabled, a break occurs when all 16 address lines match.
// - With break disabled, address matches are ignored.
// - The autovector enable bit turns automatic vectoring on or off.
// - Endpoint request flag sets when its busy indication falls from one to zero.
// - Raising the interrupt request updates the vector register with its source.
`ifndef USB_IRQ_DEFS_SVH
`define USB_IRQ_DEFS_SVH

`define ADDR_W         18
`define IDX_IRQ_VECTOR_REG       16'h7fa8
`define IDX_IN_REQ     16'h7fa9
`define IDX_OUT_REQ    16'h7faa
`define IDX_USB_REQ    16'h7fab
`define IDX_IN_EN      16'h7fac
`define IDX_OUT_EN     16'h7fad
`define IDX_USB_EN     16'h7fae
`define IDX_BAV        16'h7faf
`define IDX_BP_HIGH    16'h7fb2
`define IDX_BP_LOW     16'h7fb3

`define EVT_BUS_RESET  4
`define EVT_SUSPEND    3
`define EVT_SETUP_TOK  2
`define EVT_FRAME      1
`define EVT_SETUP_DAT  0
`define BAV_BREAK      3
`define BAV_PULSE      2
`define BAV_BRK_EN     1
`define BAV_AUTOVEC    0

`define RST_USB_EN     5'h00
`define RST_EP_EN      8'h00
`define RST_BP_ADDR    16'h0000
`define RST_IRQ_VECTOR_REG       5'h00

`define VEC_IN_BASE    5'h05
`define VEC_OUT_BASE   5'h0d

`define SUSPEND_MS     3
`define SYS_MHZ        40
`define REF_MHZ        24
`define BREAK_TICKS    4'h8
`define IDLE_W         24

`endif

// ---- design/usb_irq_pkg.sv ----
// Purpose: State types of the USB interrupt block.
// Assumes: Widths match the constants header.
// Notes:   The core and break modules keep all of their state in these structs; the flag bank declares its own.
package usb_irq_pkg;

    typedef struct packed {
        logic [4:0]  usb_en;
        logic [7:0]  in_en;
        logic [7:0]  out_en;
        logic        pulse_mode;
        logic        brk_en;
        logic        av_en;
        logic [15:0] bp_addr;
        logic [31:0] rdata;
        logic        err;
        logic [4:0]  irq_vector_reg;
        logic        irq;
        logic [7:0]  in_busy_q;
        logic [7:0]  out_busy_q;
        logic [23:0] idle_cnt;
        logic        susp_done;
    } core_state_t;

    typedef struct packed {
        logic [5:0] phase;
        logic [3:0] cnt;
        logic       flag;
    } brk_state_t;

endpackage

// ---- design/req_flag_bank.sv ----
// Purpose: Bank of sticky request flags set by hardware and cleared by writing ones.
// Assumes: Set and clear are one-cycle strobes.
// Notes:   A set in the cycle of a clear wins, so no event is lost.
`timescale 1ns/1ps
module req_flag_bank #(
    parameter int W = 8
) (
    input  wire logic         clk_sys,
    input  wire logic         rst_n,
    input  wire logic [W-1:0] set,
    input  wire logic [W-1:0] clr,
    output logic      [W-1:0] flags
);
    typedef struct packed {
        logic [W-1:0] flags;
    } bank_state_t;

    bank_state_t st_reg;
    bank_state_t st_next;

    always_comb begin
        st_next       = st_reg;
        st_next.flags = (st_reg.flags & ~clr) | set;
    end

    // Only power-on reset clears these; processor reset does not reach here
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign flags = st_reg.flags;

    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_n);

    chk_set_wins_clear: assert property ((|set) |=> ((flags & $past(set)) == $past(set)))
        else $error("set flag lost against a clear");
    chk_clear_takes: assert property ((|(clr & ~set)) |=> ((flags & $past(clr & ~set)) == '0))
        else $error("written one did not clear flag");
endmodule

// ---- design/break_pulse_unit.sv ----
// Purpose: Break flag with latched or pulsed behaviour timed in reference clock cycles.
// Assumes: The reference rate is derived from clk_sys by a fractional accumulator.
// Notes:   The first reference tick is partial, so the pulse lasts 7 to 8 reference periods.
`timescale 1ns/1ps
`include "usb_irq_defs.svh"
module break_pulse_unit
    import usb_irq_pkg::*;
(
    input  wire logic clk_sys,
    input  wire logic rst_n,
    input  wire logic hit,
    input  wire logic pulse_mode,
    input  wire logic clr,
    output logic      flag
);
    brk_state_t st_reg;
    brk_state_t st_next;
    logic       tick;
    logic [5:0] sum;

    // Phase step of REF per SYS cycle gives the reference rate without a second clock
    assign sum  = st_reg.phase + 6'(`REF_MHZ);
    assign tick = (sum >= 6'(`SYS_MHZ));

    always_comb begin
        st_next       = st_reg;
        st_next.phase = tick ? 6'(sum - 6'(`SYS_MHZ)) : sum;
        if (clr) begin
            st_next.flag = 1'b0;
            st_next.cnt  = 4'h0;
        end
        if (pulse_mode && st_reg.flag && tick && st_reg.cnt != 4'h0) begin
            st_next.cnt = st_reg.cnt - 4'h1;
            if (st_reg.cnt == 4'h1) begin
                st_next.flag = 1'b0;
            end
        end
        if (hit) begin
            st_next.flag = 1'b1;
            st_next.cnt  = pulse_mode ? `BREAK_TICKS : 4'h0;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign flag = st_reg.flag;

    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_n);

    chk_pulse_min_width: assert property (($rose(flag) && pulse_mode && !clr) |-> flag[*8])
        else $error("break pulse shorter than eight cycles");
    chk_latched_holds: assert property ((flag && !pulse_mode && !clr) |=> flag)
        else $error("latched break dropped without a clear");
    chk_pulse_ends: assert property ((flag && pulse_mode && st_reg.cnt == 4'h1 && tick && !hit)
                                     |=> !flag)
        else $error("break pulse did not end");
endmodule

// ---- design/usb_irq_core.sv ----
// Purpose: USB event and endpoint interrupt requests, enables, vector and address breakpoint.
// Assumes: APB slave with no wait states; event inputs are one-cycle pulses from the core.
// Notes:   rst_n is the power-on reset; processor reset does not clear the request flags.
//
// The APB slave port was left to the implementer.
`timescale 1ns/1ps
`include "usb_irq_defs.svh"
module usb_irq_core
    import usb_irq_pkg::*;
#(
    parameter int SUSPEND_CYCLES = `SUSPEND_MS * `SYS_MHZ * 1000
) (
    input  wire logic               clk_sys,
    input  wire logic               rst_n,
    input  wire logic               psel,
    input  wire logic               penable,
    input  wire logic               pwrite,
    input  wire logic [`ADDR_W-1:0] paddr,
    input  wire logic [31:0]        pwdata,
    output logic      [31:0]        prdata,
    output logic                    pready,
    output logic                    pslverr,
    input  wire logic               usb_reset_seen,
    input  wire logic               bus_activity,
    input  wire logic               setup_token_seen,
    input  wire logic               frame_start_seen,
    input  wire logic               setup_bytes_done,
    input  wire logic [7:0]         in_busy,
    input  wire logic [7:0]         out_busy,
    input  wire logic [15:0]        cpu_addr,
    output logic                    usb_irq_line,
    output logic [4:0]              irq_vector,
    output logic                    autovector_enable,
    output logic                    break_out_pin
);
    core_state_t st_reg;
    core_state_t st_next;

    logic [4:0] evt_flags;
    logic [7:0] in_flags;
    logic [7:0] out_flags;
    logic       brk_flag;
    logic [4:0] evt_set;
    logic [4:0] evt_clr;
    logic [7:0] in_clr;
    logic [7:0] out_clr;
    logic [7:0] in_fall;
    logic [7:0] out_fall;
    logic       susp_set;
    logic       brk_hit;
    logic       brk_clr;
    logic       wr_acc;
    logic       setup_ph;
    logic [4:0] ev_pend;
    logic [7:0] in_pend;
    logic [7:0] out_pend;
    logic       pend_any;

    function automatic logic at_idx(input logic [`ADDR_W-1:0] a, input logic [15:0] idx);
        return a == {idx, 2'b00};
    endfunction

    // Lowest code wins: events first, then IN, then OUT endpoints
    function automatic logic [4:0] pick_src(input logic [4:0] ev, input logic [7:0] inp,
                                            input logic [7:0] outp);
        logic [4:0] code;
        code = `RST_IRQ_VECTOR_REG;
        for (int i = 7; i >= 0; i--) begin
            if (outp[i]) begin
                code = 5'(`VEC_OUT_BASE + 5'(i));
            end
        end
        for (int i = 7; i >= 0; i--) begin
            if (inp[i]) begin
                code = 5'(`VEC_IN_BASE + 5'(i));
            end
        end
        for (int i = 4; i >= 0; i--) begin
            if (ev[i]) begin
                code = 5'(i);
            end
        end
        return code;
    endfunction

    assign setup_ph = psel && !penable;
    assign wr_acc   = psel && penable && pwrite;
    assign pready   = 1'b1;
    assign pslverr  = psel && penable && st_reg.err;
    assign prdata   = st_reg.rdata;

    // Suspend flags once per idle stretch, re-armed by any bus activity
    assign susp_set = !bus_activity && !st_reg.susp_done
                      && (st_reg.idle_cnt == 24'(SUSPEND_CYCLES - 1));

    assign evt_set[`EVT_BUS_RESET] = usb_reset_seen;
    assign evt_set[`EVT_SUSPEND]   = susp_set;
    assign evt_set[`EVT_SETUP_TOK] = setup_token_seen;
    assign evt_set[`EVT_FRAME]     = frame_start_seen;
    assign evt_set[`EVT_SETUP_DAT] = setup_bytes_done;

    assign in_fall  = st_reg.in_busy_q & ~in_busy;
    assign out_fall = st_reg.out_busy_q & ~out_busy;

    // Writes of ones clear; a read-modify-write would clear every pending flag
    assign evt_clr = (wr_acc && at_idx(paddr, `IDX_USB_REQ)) ? pwdata[4:0] : 5'h00;
    assign in_clr  = (wr_acc && at_idx(paddr, `IDX_IN_REQ)) ? pwdata[7:0] : 8'h00;
    assign out_clr = (wr_acc && at_idx(paddr, `IDX_OUT_REQ)) ? pwdata[7:0] : 8'h00;
    assign brk_clr = wr_acc && at_idx(paddr, `IDX_BAV) && pwdata[`BAV_BREAK];

    assign brk_hit = st_reg.brk_en && (cpu_addr == st_reg.bp_addr);

    // Enables only gate the request line and the vector choice; flags and endpoints never see them
    assign ev_pend  = evt_flags & st_reg.usb_en;
    assign in_pend  = in_flags & st_reg.in_en;
    assign out_pend = out_flags & st_reg.out_en;
    assign pend_any = |{ev_pend, in_pend, out_pend};

    req_flag_bank #(.W(5)) u_evt (
        .clk_sys (clk_sys),
        .rst_n   (rst_n),
        .set     (evt_set),
        .clr     (evt_clr),
        .flags   (evt_flags)
    );

    req_flag_bank #(.W(16)) u_ep (
        .clk_sys (clk_sys),
        .rst_n   (rst_n),
        .set     ({out_fall, in_fall}),
        .clr     ({out_clr, in_clr}),
        .flags   ({out_flags, in_flags})
    );

    break_pulse_unit u_brk (
        .clk_sys    (clk_sys),
        .rst_n      (rst_n),
        .hit        (brk_hit),
        .pulse_mode (st_reg.pulse_mode),
        .clr        (brk_clr),
        .flag       (brk_flag)
    );

    always_comb begin
        st_next            = st_reg;
        st_next.in_busy_q  = in_busy;
        st_next.out_busy_q = out_busy;
        if (bus_activity) begin
            st_next.idle_cnt  = '0;
            st_next.susp_done = 1'b0;
        end else if (susp_set) begin
            st_next.susp_done = 1'b1;
        end else if (!st_reg.susp_done) begin
            st_next.idle_cnt = st_reg.idle_cnt + 24'h1;
        end
        st_next.irq = pend_any;
        if (pend_any) begin
            st_next.irq_vector_reg = pick_src(ev_pend, in_pend, out_pend);
        end
        if (setup_ph) begin
            st_next.err   = 1'b0;
            st_next.rdata = 32'h0000_0000;
            if (at_idx(paddr, `IDX_IRQ_VECTOR_REG)) begin
                st_next.rdata = {24'h0, 1'b0, st_reg.irq_vector_reg, 2'b00};
            end else if (at_idx(paddr, `IDX_IN_REQ)) begin
                st_next.rdata = {24'h0, in_flags};
            end else if (at_idx(paddr, `IDX_OUT_REQ)) begin
                st_next.rdata = {24'h0, out_flags};
            end else if (at_idx(paddr, `IDX_USB_REQ)) begin
                st_next.rdata = {27'h0, evt_flags};
            end else if (at_idx(paddr, `IDX_IN_EN)) begin
                st_next.rdata = {24'h0, st_reg.in_en};
            end else if (at_idx(paddr, `IDX_OUT_EN)) begin
                st_next.rdata = {24'h0, st_reg.out_en};
            end else if (at_idx(paddr, `IDX_USB_EN)) begin
                st_next.rdata = {27'h0, st_reg.usb_en};
            end else if (at_idx(paddr, `IDX_BAV)) begin
                st_next.rdata = {28'h0, brk_flag, st_reg.pulse_mode, st_reg.brk_en,
                                 st_reg.av_en};
            end else if (at_idx(paddr, `IDX_BP_HIGH)) begin
                st_next.rdata = {24'h0, st_reg.bp_addr[15:8]};
            end else if (at_idx(paddr, `IDX_BP_LOW)) begin
                st_next.rdata = {24'h0, st_reg.bp_addr[7:0]};
            end else begin
                st_next.err = 1'b1;
            end
        end
        if (wr_acc && !st_reg.err) begin
            if (at_idx(paddr, `IDX_IN_EN)) begin
                st_next.in_en = pwdata[7:0];
            end
            if (at_idx(paddr, `IDX_OUT_EN)) begin
                st_next.out_en = pwdata[7:0];
            end
            if (at_idx(paddr, `IDX_USB_EN)) begin
                st_next.usb_en = pwdata[4:0];
            end
            if (at_idx(paddr, `IDX_BAV)) begin
                st_next.pulse_mode = pwdata[`BAV_PULSE];
                st_next.brk_en     = pwdata[`BAV_BRK_EN];
                st_next.av_en      = pwdata[`BAV_AUTOVEC];
            end
            if (at_idx(paddr, `IDX_BP_HIGH)) begin
                st_next.bp_addr[15:8] = pwdata[7:0];
            end
            if (at_idx(paddr, `IDX_BP_LOW)) begin
                st_next.bp_addr[7:0] = pwdata[7:0];
            end
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            st_reg         <= '0;
            st_reg.usb_en  <= `RST_USB_EN;
            st_reg.in_en   <= `RST_EP_EN;
            st_reg.out_en  <= `RST_EP_EN;
            st_reg.bp_addr <= `RST_BP_ADDR;
            st_reg.irq_vector_reg    <= `RST_IRQ_VECTOR_REG;
        end else begin
            st_reg <= st_next;
        end
    end

    assign usb_irq_line      = st_reg.irq;
    assign irq_vector        = st_reg.irq_vector_reg;
    assign autovector_enable = st_reg.av_en;
    assign break_out_pin     = brk_flag;

    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_n);

    chk_bus_reset_flag: assert property (usb_reset_seen |=> evt_flags[`EVT_BUS_RESET])
        else $error("bus reset did not set its flag");
    chk_token_flag: assert property (setup_token_seen |=> evt_flags[`EVT_SETUP_TOK])
        else $error("setup token did not set its flag");
    chk_bytes_flag: assert property (setup_bytes_done |=> evt_flags[`EVT_SETUP_DAT])
        else $error("setup bytes did not set their flag");
    chk_frame_raises_irq: assert property ((frame_start_seen && st_reg.usb_en[`EVT_FRAME]
                                            && st_next.usb_en[`EVT_FRAME])
                                           |-> ##2 usb_irq_line)
        else $error("enabled frame event did not raise the line");
    chk_masked_quiet: assert property ((st_reg.usb_en == 5'h00 && st_reg.in_en == 8'h00
                                        && st_reg.out_en == 8'h00) |=> !usb_irq_line)
        else $error("line raised with every source masked");
    chk_busy_fall_flag: assert property ($fell(in_busy[2]) |=> in_flags[2])
        else $error("busy fall did not set endpoint flag");
    chk_break_needs_match: assert property ($rose(break_out_pin)
        |-> $past(st_reg.brk_en && cpu_addr == st_reg.bp_addr))
        else $error("break without enabled address match");
    // Only a lone pending source pins down the code; event bits 0 to 3 would outrank it
    chk_vector_updated: assert property ($rose(usb_irq_line)
        && $past(ev_pend) == (5'h01 << `EVT_BUS_RESET) && $past({in_pend, out_pend}) == 16'h0000
        |-> irq_vector == 5'(`EVT_BUS_RESET))
        else $error("vector did not follow the raised source");

    // Flags must survive a masked enable; the line is only their gated OR
    chk_suspend_flag: assert property (susp_set
        |=> evt_flags[`EVT_SUSPEND])
        else $error("suspend did not set its flag");
    chk_frame_flag: assert property (frame_start_seen
        |=> evt_flags[`EVT_FRAME])
        else $error("frame start did not set its flag");
    chk_token_held: assert property ((evt_flags[`EVT_SETUP_TOK] && !evt_clr[`EVT_SETUP_TOK])
        |=> evt_flags[`EVT_SETUP_TOK])
        else $error("token flag dropped without a clear");
    chk_out_fall_flag: assert property ($fell(out_busy[1])
        |=> out_flags[1])
        else $error("busy fall did not set OUT flag");
    chk_event_gated: assert property ((|(evt_flags & st_reg.usb_en))
        |=> usb_irq_line)
        else $error("enabled event did not raise the line");
    chk_masked_event_quiet: assert property ((evt_flags == 5'h02 && st_reg.usb_en == 5'h00
        && {in_flags, out_flags} == 16'h0000) |=> !usb_irq_line)
        else $error("masked event raised the line");
    chk_endpoint_gated: assert property ((|{in_flags & st_reg.in_en, out_flags & st_reg.out_en})
        |=> usb_irq_line)
        else $error("enabled endpoint did not raise the line");
    chk_in_held: assert property ((in_flags[2] && !st_reg.in_en[2] && !in_clr[2])
        |=> in_flags[2])
        else $error("masked IN flag was lost");
    chk_out_held: assert property ((out_flags[1] && !st_reg.out_en[1] && !out_clr[1])
        |=> out_flags[1])
        else $error("masked OUT flag was lost");
    chk_line_needs_source: assert property ($rose(usb_irq_line)
        |-> $past(|{ev_pend, in_pend, out_pend}))
        else $error("line rose with nothing enabled pending");
    chk_break_on_match: assert property ((st_reg.brk_en && cpu_addr == st_reg.bp_addr)
        |=> break_out_pin)
        else $error("enabled match did not raise the break pin");
    chk_break_disabled: assert property ((!st_reg.brk_en && !break_out_pin)
        |=> !break_out_pin)
        else $error("break raised while disabled");
    chk_autovector_copy: assert property ((wr_acc && at_idx(paddr, `IDX_BAV) && !st_reg.err)
        |=> autovector_enable == $past(pwdata[`BAV_AUTOVEC]))
        else $error("autovector enable not taken from write");

    cov_frame_irq: cover property (frame_start_seen ##2 usb_irq_line);
    cov_latched_break: cover property ($rose(break_out_pin) && !st_reg.pulse_mode);
    cov_pulse_break: cover property ($rose(break_out_pin) && st_reg.pulse_mode);
    cov_suspend: cover property (susp_set);
    cov_endpoint_irq: cover property ((|in_pend) ##1 usb_irq_line);
endmodule

// ---- bench/cpu_model.sv ----
// Purpose: Processor-side model that reaches the interrupt block over APB.
// Assumes: One transfer at a time; signals change only on rising edges.
// Notes:   Flags are cleared by writing the mask alone, never by read-or-write.
`timescale 1ns/1ps
module cpu_model (
    input  wire logic        clk_sys,
    output logic             psel,
    output logic             penable,
    output logic             pwrite,
    output logic [17:0]      paddr,
    output logic [31:0]      pwdata,
    input  wire logic [31:0] prdata,
    input  wire logic        pready,
    input  wire logic        pslverr
);
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 18'h00000;
        pwdata = 32'h00000000;
    end

    // Request is held until pready is seen high, then released
    task automatic xfer(input logic w, input logic [15:0] idx, input logic [31:0] d,
                        output logic [31:0] r, output logic e);
        @(posedge clk_sys);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= {idx, 2'b00};
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        do @(posedge clk_sys); while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        pwdata <= ~d;
    endtask

    // Only the bits to be cleared are written, so other pending flags survive
    task automatic clear_mask(input logic [15:0] idx, input logic [7:0] m);
        logic [31:0] r;
        logic        e;
        xfer(1'b1, idx, {24'h000000, m}, r, e);
    endtask
endmodule

// ---- bench/usb_irq_core_tb_top.sv ----
// Purpose: Self-checking bench for the USB interrupt and breakpoint block.
// Assumes: Suspend count shortened to 20 cycles; APB answers are awaited, not counted.
// Notes:   The processor enables its own interrupt input; this bench watches the line.
`timescale 1ns/1ps
`include "usb_irq_defs.svh"
module usb_irq_core_tb_top;
    logic        clk_sys, rst_n, psel, penable, pwrite, pready, pslverr;
    logic [17:0] paddr;
    logic [31:0] pwdata, prdata, rd_val;
    logic        usb_reset_seen, bus_activity, setup_token_seen, frame_start_seen;
    logic        setup_bytes_done, usb_irq_line, autovector_enable, break_out_pin, err;
    logic [7:0]  in_busy, out_busy;
    logic [15:0] cpu_addr;
    logic [4:0]  irq_vector;
    int          n_errors, tests_run, cycles;

    cpu_model u_cpu (.clk_sys(clk_sys), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));

    usb_irq_core #(.SUSPEND_CYCLES(20)) u_dut (.clk_sys(clk_sys), .rst_n(rst_n),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .usb_reset_seen(usb_reset_seen), .bus_activity(bus_activity),
        .setup_token_seen(setup_token_seen), .frame_start_seen(frame_start_seen),
        .setup_bytes_done(setup_bytes_done), .in_busy(in_busy), .out_busy(out_busy),
        .cpu_addr(cpu_addr), .usb_irq_line(usb_irq_line), .irq_vector(irq_vector),
        .autovector_enable(autovector_enable), .break_out_pin(break_out_pin));

    initial begin
        clk_sys = 1'b0;
        forever #12.5 clk_sys = ~clk_sys;
    end

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_errors++;
            $display("unexpected %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic final_report();
        $display("checks %0d errors %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    task automatic wr(input logic [15:0] idx, input logic [7:0] d);
        u_cpu.xfer(1'b1, idx, {24'h000000, d}, rd_val, err);
    endtask

    task automatic rd(input logic [15:0] idx);
        u_cpu.xfer(1'b0, idx, 32'h00000000, rd_val, err);
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask

    // One source event of the USB core, by event bit position
    task automatic fire(input int i);
        @(posedge clk_sys);
        case (i)
            0: setup_bytes_done <= 1'b1;
            1: frame_start_seen <= 1'b1;
            2: setup_token_seen <= 1'b1;
            3: bus_activity <= 1'b0;
            default: usb_reset_seen <= 1'b1;
        endcase
        repeat (i == 3 ? 25 : 1) @(posedge clk_sys);
        {usb_reset_seen, setup_token_seen, frame_start_seen, setup_bytes_done} <= 4'h0;
        bus_activity <= 1'b1;
        tick(3);
    endtask

    task automatic hit();
        @(posedge clk_sys);
        cpu_addr <= 16'h1234;
        @(posedge clk_sys);
        cpu_addr <= 16'h0000;
    endtask

    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 6000) begin
            n_errors++;
            final_report();
        end
    end

    initial begin
        {rst_n, usb_reset_seen, setup_token_seen, frame_start_seen, setup_bytes_done} = 5'h00;
        bus_activity = 1'b1;
        in_busy = 8'h00;
        out_busy = 8'h00;
        cpu_addr = 16'h0000;
        n_errors = 0;
        tests_run = 0;
        cycles = 0;
        repeat (5) @(posedge clk_sys);
        rst_n <= 1'b1;
        rd(`IDX_USB_REQ);  check("event req rst", rd_val, 32'h0);
        rd(`IDX_IN_EN);    check("in en rst", rd_val, 32'h0);
        rd(`IDX_USB_EN);   check("event en rst", rd_val, 32'h0);
        rd(`IDX_BAV);      check("control rst", rd_val, 32'h0);
        rd(16'h7fb0);      check("unmapped err", {31'h0, err}, 32'h1);
        for (int i = 0; i < 5; i++) begin
            fire(i);
            rd(`IDX_USB_REQ);  check("event flag", rd_val, 32'h1 << i);
            tick(1);           check("masked line", usb_irq_line, 1'b0);
            wr(`IDX_USB_EN, 8'h01 << i);
            tick(2);           check("event line", usb_irq_line, 1'b1);
            check("event vector", irq_vector, i[4:0]);
            u_cpu.clear_mask(`IDX_USB_REQ, 8'h01 << i);
            rd(`IDX_USB_REQ);  check("event cleared", rd_val, 32'h0);
            wr(`IDX_USB_EN, 8'h00);
        end
        wr(`IDX_USB_EN, 8'h02);
        fire(1);           check("frame line", usb_irq_line, 1'b1);
        fire(2);           check("frame vector", irq_vector, 5'h01);
        u_cpu.clear_mask(`IDX_USB_REQ, 8'h02);
        rd(`IDX_USB_REQ);  check("mask clear", rd_val, 32'h4);
        tick(1);           check("token masked", usb_irq_line, 1'b0);
        u_cpu.clear_mask(`IDX_USB_REQ, 8'h04);
        wr(`IDX_USB_EN, 8'h00);
        for (int j = 0; j < 2; j++) begin
            @(posedge clk_sys);
            if (j == 0) in_busy <= 8'h04; else out_busy <= 8'h02;
            @(posedge clk_sys);
            in_busy <= 8'h00;
            out_busy <= 8'h00;
            rd(j == 0 ? `IDX_IN_REQ : `IDX_OUT_REQ);
            check("ep flag", rd_val, j == 0 ? 32'h4 : 32'h2);
            tick(1);           check("ep held", usb_irq_line, 1'b0);
            wr(j == 0 ? `IDX_IN_EN : `IDX_OUT_EN, j == 0 ? 8'h04 : 8'h02);
            tick(2);           check("ep line", usb_irq_line, 1'b1);
            check("ep vector", irq_vector, j == 0 ? 5'h07 : 5'h0e);
            u_cpu.clear_mask(j == 0 ? `IDX_IN_REQ : `IDX_OUT_REQ, 8'hff);
            tick(2);           check("ep line off", usb_irq_line, 1'b0);
        end
        wr(`IDX_BP_HIGH, 8'h12);
        wr(`IDX_BP_LOW, 8'h34);
        hit();
        tick(3);           check("break off", break_out_pin, 1'b0);
        wr(`IDX_BAV, 8'h02);
        hit();
        tick(3);           check("break pin", break_out_pin, 1'b1);
        rd(`IDX_BAV);      check("break flag", rd_val, 32'ha);
        tick(30);          check("break latched", break_out_pin, 1'b1);
        wr(`IDX_BAV, 8'h0a);
        tick(2);           check("break cleared", break_out_pin, 1'b0);
        wr(`IDX_BAV, 8'h06);
        hit();
        tick(4);           check("pulse high", break_out_pin, 1'b1);
        tick(20);          check("pulse ended", break_out_pin, 1'b0);
        wr(`IDX_BAV, 8'h01);
        tick(2);           check("autovector", autovector_enable, 1'b1);
        final_report();
    end
endmodule
